// ### wdms_chk_asserts.sv
`timescale 1ns/1ps
module wdms_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire wdms_pkg::wdms_bus_t i_bus,
    input wire logic i_irq_mask,
    input wire logic i_halt_exec,
    input wire logic i_stop_mode,
    input wire logic o_reset_pin_n,
    input wire logic o_reset_pin_oe,
    input wire logic o_halt_inhibit,
    input wire logic o_op_clk_en,
    input wire wdms_pkg::wdms_ctrl_t o_ctrl
);
    import wdms_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire wm = i_bus.wr && i_bus.addr == MISC_OFFSET;
    property p_en; wm && i_bus.wdata[BIT_WATCHDOG_ENABLE_REFRESH] |-> ##2 o_ctrl.watchdog_enable_refresh_on; endproperty
    a_en: assert property (p_en) else $error("enable lost");
    property p_stay; o_ctrl.watchdog_enable_refresh_on |=> o_ctrl.watchdog_enable_refresh_on; endproperty
    a_stay: assert property (p_stay) else $error("enable cleared");
    property p_pin; !o_reset_pin_n |-> o_reset_pin_oe; endproperty
    a_pin: assert property (p_pin) else $error("pin not driven");
    property p_pull; $fell(o_reset_pin_n) |=> !o_reset_pin_n; endproperty
    a_pull: assert property (p_pull) else $error("pull too short");
    property p_halt; i_halt_exec && o_halt_inhibit |-> ##[1:2] !o_reset_pin_n; endproperty
    a_halt: assert property (p_halt) else $error("halt no reset");
    property p_irq; wm && !i_irq_mask |-> ##2 $stable(o_ctrl.irq_pos_sel); endproperty
    a_irq: assert property (p_irq) else $error("select changed");
    property p_stop; i_stop_mode |-> ##2 !o_ctrl.slow_sel; endproperty
    a_stop: assert property (p_stop) else $error("slow kept");
    property p_clk; o_op_clk_en |=> !o_op_clk_en; endproperty
    a_clk: assert property (p_clk) else $error("clock pulse wide");
    cover property (!o_reset_pin_n);
    cover property (o_ctrl.slow_sel && o_op_clk_en);
    cover property (i_halt_exec && o_halt_inhibit);
endmodule
bind wdms_top wdms_chk wdms_chk_inst (.*);

// ### wdms_pkg.sv
package wdms_pkg;
    localparam logic [7:0] MISC_OFFSET = 8'h0c;
    localparam logic [7:0] MISC_RESET = 8'h10;
    localparam int BIT_WATCHDOG_ENABLE_REFRESH = 0;
    localparam int BIT_SLOW = 1;
    localparam int BIT_NEG = 5;
    localparam int BIT_POS = 6;
    localparam logic [7:0] MISC_USED_MASK = 8'h63;
    localparam int PRESCALE_DIV = 1024;
    localparam int WATCHDOG_ENABLE_REFRESH_MAX = 8;
    localparam int SLOW_DIV = 16;
    localparam int OSC_DIV = 2;
    localparam int CLK_PERIOD_NS = 100;
    // Reset pin pull: least 1.5 cycles, rounded up
    localparam int RST_PULL_HALF_CYCLES = 3;
    localparam int RST_PULL_CYCLES = (RST_PULL_HALF_CYCLES + 1) / 2;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdms_bus_t;

    typedef struct packed {
        logic irq_pos_sel;
        logic irq_neg_sel;
        logic slow_sel;
        logic watchdog_enable_refresh_on;
    } wdms_ctrl_t;
endpackage

// ### wdms_tb.sv
`timescale 1ns/1ps
module tb_top;
    import wdms_pkg::*;
    logic i_clk = 0, i_rst_n = 0, i_irq_mask = 0, i_wait_mode = 0, i_halt_exec = 0;
    logic i_stop_mode = 0, o_reset_pin_n, o_reset_pin_oe, o_halt_inhibit, o_op_clk_en;
    logic [7:0] o_rdata;
    wdms_bus_t i_bus = '0;
    wdms_ctrl_t o_ctrl;
    int miscompares = 0, compares = 0, cyc = 0, n;
    initial forever #50 i_clk = ~i_clk;
    wdms_top wdms_top_inst (.i_clk, .i_rst_n, .i_bus, .i_irq_mask, .i_wait_mode,
        .i_halt_exec, .i_stop_mode, .o_rdata, .o_reset_pin_n, .o_reset_pin_oe,
        .o_halt_inhibit, .o_op_clk_en, .o_ctrl);
    task automatic chk(input string s, input logic [15:0] v, e);
        compares++;
        if (v !== e) begin
            miscompares++;
            $display("FAIL %s exp %h seen %h", s, e, v);
        end
    endtask
    task automatic w(input logic [7:0] a, d);
        @(posedge i_clk) i_bus <= '{a, d, 1'h1, 1'h0};
        @(posedge i_clk) i_bus.wr <= 1'h0;
    endtask
    task automatic r(input logic [7:0] a, e);
        @(posedge i_clk) i_bus <= '{a, 8'h00, 1'h0, 1'h1};
        @(posedge i_clk) i_bus.rd <= 1'h0;
        #1 chk("rdata", o_rdata, e);
    endtask
    task automatic t_regs;
        r(MISC_OFFSET, 8'h00);
        r(8'h0d, 8'h00);
        @(posedge i_clk) i_irq_mask <= 1'h1;
        w(MISC_OFFSET, 8'h63);
        repeat (40) @(posedge i_clk);
        r(MISC_OFFSET, 8'h63);
        @(posedge i_clk) i_irq_mask <= 1'h0;
        w(MISC_OFFSET, 8'h00);
        r(MISC_OFFSET, 8'h61);
    endtask
    task automatic t_refresh;
        int lows;
        lows = 0;
        repeat (3) begin
            w(MISC_OFFSET, 8'h01);
            repeat (5 * PRESCALE_DIV) begin
                @(negedge i_clk);
                if (o_reset_pin_n !== 1'h1) lows++;
            end
        end
        chk("refresh", lows, 16'h0);
    endtask
    task automatic clk_gap(input int e);
        int g;
        g = 0;
        repeat (40) @(negedge i_clk);
        @(negedge i_clk iff o_op_clk_en === 1'h1);
        do begin
            @(negedge i_clk);
            g++;
        end while (o_op_clk_en !== 1'h1 && g < 100);
        chk("clk_gap", g, e);
    endtask
    task automatic t_clock;
        w(MISC_OFFSET, 8'h03);
        clk_gap(OSC_DIV * SLOW_DIV);
        chk("slow_sel", o_ctrl.slow_sel, 16'h1);
        w(MISC_OFFSET, 8'h01);
        clk_gap(OSC_DIV);
        chk("slow_sel", o_ctrl.slow_sel, 16'h0);
    endtask
    task automatic t_timeout;
        @(posedge i_clk) i_stop_mode <= 1'h1;
        @(posedge i_clk) i_stop_mode <= 1'h0;
        w(MISC_OFFSET, 8'h01);
        i_wait_mode <= 1'h1;
        n = 0;
        while (o_reset_pin_n !== 1'h0 && n < 9000) begin
            @(negedge i_clk);
            n++;
        end
        chk("timeout", n >= (WATCHDOG_ENABLE_REFRESH_MAX - 1) * PRESCALE_DIV, 16'h1);
        chk("timeout", n <= WATCHDOG_ENABLE_REFRESH_MAX * PRESCALE_DIV + 4, 16'h1);
        i_wait_mode <= 1'h0;
    endtask
    task automatic t_halt;
        @(posedge i_clk) i_rst_n <= 1'h0;
        @(posedge i_clk) i_rst_n <= 1'h1;
        r(MISC_OFFSET, 8'h00);
        chk("inhibit", o_halt_inhibit, 16'h0);
        w(MISC_OFFSET, 8'h01);
        repeat (3) @(posedge i_clk);
        #1 chk("inhibit", o_halt_inhibit, 16'h1);
        @(posedge i_clk) i_halt_exec <= 1'h1;
        @(posedge i_clk) i_halt_exec <= 1'h0;
        @(negedge i_clk);
        @(negedge i_clk) chk("halt", o_reset_pin_n, 16'h0);
        chk("pin_oe", o_reset_pin_oe, 16'h1);
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'h1;
        t_regs;
        t_refresh;
        t_clock;
        t_timeout;
        t_halt;
        report_and_stop;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 45000) begin
            miscompares++;
            report_and_stop;
        end
    end
endmodule

// ### wdms_top.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Functional notes
// R1: Watchdog is 1024 prescaler plus count-to-8
// R2: Programmable option: reset disables, zeroes counter
// R3: Writing one to enable bit starts watchdog
// R4: Only reset clears enable bit once set
// R5: Counter advances every 1024 cycles when enabled
// R6: Writing one to enable bit zeroes counter
// R7: Counter reaching eight raises system reset
// R8: Prescaler not cleared when watchdog enabled
// R9: Software refreshes before timeout; first within six
// R10: Timeout pulls reset pin low 1.5+ cycles
// R11: Active-during-wait option keeps counting in wait
// R12: Suspended-during-wait option stops, zeroes in wait
// R13: Halt while enabled gives immediate watchdog reset
// R14: Register resets to 10h; unused bits read zero
// R15: Trigger select writes only while mask set
// R16: Slow bit adds divide-by-16 clock stage
// R17: Operating clock is oscillator divided by two
// R18: Slow mode ends on clear or stop
// R19: Options are fixed build parameters
module wdms_top #(
    parameter bit PROG_ENABLE = 1'b1,
    parameter bit ACTIVE_IN_WAIT = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire wdms_pkg::wdms_bus_t i_bus,
    input wire logic i_irq_mask,
    input wire logic i_wait_mode,
    input wire logic i_halt_exec,
    input wire logic i_stop_mode,
    output logic [7:0] o_rdata,
    output logic o_reset_pin_n,
    output logic o_reset_pin_oe,
    output logic o_halt_inhibit,
    output logic o_op_clk_en,
    output wdms_pkg::wdms_ctrl_t o_ctrl
);
    import wdms_pkg::*;

    localparam int PW = $clog2(PRESCALE_DIV);
    localparam int CW = $clog2(WATCHDOG_ENABLE_REFRESH_MAX) + 1;
    localparam int SW = $clog2(SLOW_DIV);
    localparam int RW = $clog2(RST_PULL_CYCLES + 1) + 1;

    logic [7:0] misc_reg;
    logic [PW-1:0] pre_reg;
    logic [CW-1:0] cnt_reg;
    logic [RW-1:0] pull_reg;
    logic osc_div_reg;
    logic [SW-1:0] slow_reg;
    logic misc_wr;
    logic refresh;
    logic tick;
    logic wd_on;
    logic suspended;
    logic fire;

    assign misc_wr = i_bus.wr && (i_bus.addr == MISC_OFFSET);
    assign refresh = misc_wr && i_bus.wdata[BIT_WATCHDOG_ENABLE_REFRESH]; // R6
    assign wd_on = PROG_ENABLE ? misc_reg[BIT_WATCHDOG_ENABLE_REFRESH] : 1'b1; // R19
    assign suspended = !ACTIVE_IN_WAIT && i_wait_mode; // R12
    assign tick = (pre_reg == PW'(PRESCALE_DIV - 1)); // R5
    assign fire = wd_on && ((cnt_reg == CW'(WATCHDOG_ENABLE_REFRESH_MAX)) || i_halt_exec); // R7 R13

    // Misc register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            misc_reg <= MISC_RESET; // R14 R2
        end else begin
            if (misc_wr) begin
                if (i_bus.wdata[BIT_WATCHDOG_ENABLE_REFRESH]) begin
                    misc_reg[BIT_WATCHDOG_ENABLE_REFRESH] <= 1'b1; // R3 R4
                end
                misc_reg[BIT_SLOW] <= i_bus.wdata[BIT_SLOW]; // R16
                if (i_irq_mask) begin
                    misc_reg[BIT_POS] <= i_bus.wdata[BIT_POS]; // R15
                    misc_reg[BIT_NEG] <= i_bus.wdata[BIT_NEG]; // R15
                end
            end
            if (i_stop_mode) begin
                misc_reg[BIT_SLOW] <= 1'b0; // R18
            end
        end
    end

    // Free-running prescaler, never cleared on enable
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + PW'(1); // R1 R8
        end
    end

    // Watchdog counter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0; // R2
        end else if (refresh || suspended || !wd_on || fire) begin
            cnt_reg <= '0; // R6 R12
        end else if (tick && cnt_reg != CW'(WATCHDOG_ENABLE_REFRESH_MAX)) begin
            cnt_reg <= cnt_reg + CW'(1); // R1 R5 R11
        end
    end

    // Reset pin pull on timeout
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pull_reg <= '0;
            o_reset_pin_n <= 1'b1;
            o_reset_pin_oe <= 1'b0;
        end else begin
            if (fire) begin
                pull_reg <= RW'(RST_PULL_CYCLES); // R10
            end else if (pull_reg != '0) begin
                pull_reg <= pull_reg - RW'(1);
            end
            o_reset_pin_n <= !(fire || pull_reg != '0); // R10
            o_reset_pin_oe <= fire || pull_reg != '0;
        end
    end

    // Clock path: divide by two, optional divide by sixteen
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_div_reg <= 1'b0;
            slow_reg <= '0;
            o_op_clk_en <= 1'b0;
        end else begin
            osc_div_reg <= !osc_div_reg; // R17
            if (osc_div_reg) begin
                slow_reg <= slow_reg + SW'(1);
            end
            o_op_clk_en <= osc_div_reg && (!misc_reg[BIT_SLOW] || slow_reg == '1); // R16 R18
        end
    end

    // Read port and status outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
            o_halt_inhibit <= 1'b0;
            o_ctrl <= '0;
        end else begin
            o_rdata <= (i_bus.rd && i_bus.addr == MISC_OFFSET) ?
                (misc_reg & MISC_USED_MASK) : 8'h00;
            o_halt_inhibit <= wd_on; // R13
            o_ctrl.irq_pos_sel <= misc_reg[BIT_POS];
            o_ctrl.irq_neg_sel <= misc_reg[BIT_NEG];
            o_ctrl.slow_sel <= misc_reg[BIT_SLOW];
            o_ctrl.watchdog_enable_refresh_on <= wd_on;
        end
    end
endmodule
